// >>> dec_unit.sv
// Debug event condition unit: twelve event channels, branch and software
// trace selection, actions, chaining, APB registers and interrupt.
// Assumes all inputs are synchronous to pclk; APB slave with no wait states.
`timescale 1ns/1ps
`include "dec_map.svh"

module dec_unit #(
   parameter int NCH = 12,
   parameter int CW  = 16
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Processor buses
   input  wire logic        cpu_acc_valid,
   input  wire logic        cpu_acc_write,
   input  wire logic [1:0]  cpu_acc_size,
   input  wire logic [31:0] cpu_addr,
   input  wire logic [31:0] cpu_data,
   input  wire logic        cpu_pc_valid,
   input  wire logic [31:0] cpu_pc,
   input  wire logic        xbus_valid,
   input  wire logic [31:0] xbus_addr,
   input  wire logic        ybus_valid,
   input  wire logic [31:0] ybus_addr,
   // System bus and instruction events
   input  wire logic        sbus_valid,
   input  wire logic [31:0] sbus_addr,
   input  wire logic [31:0] sbus_data,
   input  wire logic        tlb_load_instruction,
   input  wire logic        branch_valid,
   input  wire logic [1:0]  branch_type,
   input  wire logic        sw_trace_valid,
   // Actions
   output logic             cpu_halt,
   output logic             host_break,
   output logic             trace_capture,
   output logic [3:0]       trace_src,
   output logic             sw_trace_capture,
   output logic             perf_start,
   output logic             perf_end,
   // Interrupt
   output logic             irq
);
   import dec_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0]           gctrl_q;
   logic [`DEC_S_W-1:0]   stat_q;
   logic [`DEC_S_W-1:0]   mask_q;
   logic                  halt_q;
   logic [31:0]           ch_ctrl_q [NCH];
   logic [31:0]           ch_val_q  [NCH];
   logic [31:0]           ch_lim_q  [NCH];
   logic [CW-1:0]         ch_cnt_q  [NCH];
   logic [CW-1:0]         ch_seen_q [NCH];
   logic [NCH-1:0]        raw;
   logic [NCH-1:0]        eff;
   logic [NCH-1:0]        prereq;
   logic [NCH-1:0]        fire;
   logic [NCH-1:0][3:0]   prev;
   logic [NCH-1:0][1:0]   flg_act;
   logic                  seq_flag;
   logic                  br_hit;
   logic                  brk_evt;
   logic                  trc_evt;
   logic [3:0]            trc_src_d;
   logic                  pst_evt;
   logic                  pend_evt;
   logic                  wr_en;
   logic                  rd_setup;
   logic [31:0]           rd_d;
   logic                  hit_map;
   logic [31:0]           prdata_q;
   logic                  slverr_q;

   // Byte address of a channel register
   function automatic logic [11:0] ch_addr(input int idx,
                                           input logic [11:0] off);
      ch_addr = `DEC_CH_BASE + 12'(idx) * `DEC_CH_STRIDE + off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Channel comparators and chaining
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      dec_chan_match u_match (
         .ctrl                 (ch_ctrl_q[g]),
         .val                  (ch_val_q[g]),
         .lim                  (ch_lim_q[g]),
         .cpu_acc_valid        (cpu_acc_valid),
         .cpu_acc_write        (cpu_acc_write),
         .cpu_acc_size         (cpu_acc_size),
         .cpu_addr             (cpu_addr),
         .cpu_data             (cpu_data),
         .cpu_pc_valid         (cpu_pc_valid),
         .cpu_pc               (cpu_pc),
         .xbus_valid           (xbus_valid),
         .xbus_addr            (xbus_addr),
         .ybus_valid           (ybus_valid),
         .ybus_addr            (ybus_addr),
         .sbus_valid           (sbus_valid),
         .sbus_addr            (sbus_addr),
         .sbus_data            (sbus_data),
         .tlb_load_instruction (tlb_load_instruction),
         .hit                  (raw[g])
      );
      assign prev[g]    = ch_ctrl_q[g][`DEC_F_PREV_HI:`DEC_F_PREV_LO];
      assign flg_act[g] = ch_ctrl_q[g][`DEC_F_FLG_HI:`DEC_F_FLG_LO];
      // Count qualification: fire on the programmed hit
      assign fire[g] = eff[g] && (!ch_ctrl_q[g][`DEC_F_CNTEN] ||
                       ch_seen_q[g] + CW'(1) >= ch_cnt_q[g]);
   end

   dec_seq #(.NCH(NCH)) u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     (raw),
      .prev    (prev),
      .flg_act (flg_act),
      .brk     (brk_evt),
      .eff     (eff),
      .prereq  (prereq),
      .flag    (seq_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // Actions
   assign br_hit = branch_valid &&
                   branch_type == gctrl_q[`DEC_G_BRTYP_HI:`DEC_G_BRTYP_LO];

   // Break, trace and performance events; prerequisites never break
   always_comb begin
      brk_evt   = br_hit && gctrl_q[`DEC_G_BRBRK];
      trc_evt   = br_hit && gctrl_q[`DEC_G_BRTR];
      trc_src_d = `DEC_SRC_BR;
      pst_evt   = 1'b0;
      pend_evt  = 1'b0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (fire[i] && !prereq[i] &&
             (ch_ctrl_q[i][`DEC_F_BRK] ||
              dec_kind_t'(ch_ctrl_q[i][`DEC_F_KIND_HI:`DEC_F_KIND_LO])
              == DEC_K_TLB))
            brk_evt = 1'b1;
         if (fire[i] && ch_ctrl_q[i][`DEC_F_TRC]) begin
            trc_evt   = 1'b1;
            trc_src_d = 4'(i + 1);
         end
         if (fire[i] && ch_ctrl_q[i][`DEC_F_PSTART])
            pst_evt = 1'b1;
         if (fire[i] && ch_ctrl_q[i][`DEC_F_PEND])
            pend_evt = 1'b1;
      end
   end

   // Hit counters restart after each firing and on every break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++)
            ch_seen_q[i] <= '0;
      end else begin
         for (int i = 0; i < NCH; i++)
            if (fire[i] || brk_evt)
               ch_seen_q[i] <= '0;
            else if (eff[i] && ch_ctrl_q[i][`DEC_F_CNTEN])
               ch_seen_q[i] <= ch_seen_q[i] + CW'(1);
      end
   end

   // Processor halt held until software resumes; a new break wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         halt_q <= 1'b0;
      else if (brk_evt)
         halt_q <= 1'b1;
      else if (wr_en && paddr == `DEC_HALT_OFF && pwdata[0])
         halt_q <= 1'b0;
   end

   // Registered action strobes toward host, trace and performance units
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_break       <= 1'b0;
         trace_capture    <= 1'b0;
         trace_src        <= 4'h0;
         sw_trace_capture <= 1'b0;
         perf_start       <= 1'b0;
         perf_end         <= 1'b0;
      end else begin
         host_break       <= brk_evt && !halt_q;
         trace_capture    <= trc_evt;
         trace_src        <= trc_evt ? trc_src_d : trace_src;
         sw_trace_capture <= sw_trace_valid && gctrl_q[`DEC_G_SWTR];
         perf_start       <= pst_evt;
         perf_end         <= pend_evt;
      end
   end

   assign cpu_halt = halt_q;

   ////////////////////////////////////////////////////////////////////////
   // Register file
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   // Global control and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gctrl_q <= `DEC_GCTRL_RST;
         mask_q  <= '0;
      end else if (wr_en) begin
         if (paddr == `DEC_GCTRL_OFF)
            gctrl_q <= pwdata;
         if (paddr == `DEC_MASK_OFF)
            mask_q <= pwdata[`DEC_S_W-1:0];
      end
   end

   // Sticky status; a new event wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         stat_q <= '0;
      else
         stat_q <= (stat_q & ~((wr_en && paddr == `DEC_STAT_OFF) ?
                    pwdata[`DEC_S_W-1:0] : '0)) |
                   {pend_evt, pst_evt, brk_evt,
                    fire[`DEC_S_BRK-1:0]};
   end

   assign irq = |(stat_q & mask_q);

   // Channel configuration words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            ch_ctrl_q[i] <= '0;
            ch_val_q[i]  <= '0;
            ch_lim_q[i]  <= '0;
            ch_cnt_q[i]  <= '0;
         end
      end else if (wr_en) begin
         for (int i = 0; i < NCH; i++) begin
            if (paddr == ch_addr(i, `DEC_CH_CTRL))
               ch_ctrl_q[i] <= pwdata;
            if (paddr == ch_addr(i, `DEC_CH_VAL))
               ch_val_q[i] <= pwdata;
            if (paddr == ch_addr(i, `DEC_CH_LIM))
               ch_lim_q[i] <= pwdata;
            if (paddr == ch_addr(i, `DEC_CH_CNT))
               ch_cnt_q[i] <= pwdata[CW-1:0];
         end
      end
   end

   // Read decode
   always_comb begin
      rd_d    = 32'h0;
      hit_map = 1'b1;
      unique case (paddr)
         `DEC_GCTRL_OFF: rd_d = gctrl_q;
         `DEC_STAT_OFF:  rd_d = {17'h0, stat_q};
         `DEC_MASK_OFF:  rd_d = {17'h0, mask_q};
         `DEC_HALT_OFF:  rd_d = {30'h0, seq_flag, halt_q};
         default: begin
            hit_map = 1'b0;
            for (int i = 0; i < NCH; i++) begin
               if (paddr == ch_addr(i, `DEC_CH_CTRL))
                  rd_d = ch_ctrl_q[i];
               if (paddr == ch_addr(i, `DEC_CH_VAL))
                  rd_d = ch_val_q[i];
               if (paddr == ch_addr(i, `DEC_CH_LIM))
                  rd_d = ch_lim_q[i];
               if (paddr == ch_addr(i, `DEC_CH_CNT))
                  rd_d = {{(32-CW){1'b0}}, ch_cnt_q[i]};
               // Any aligned word of the channel's slot is mapped
               if (paddr[1:0] == 2'h0 &&
                   paddr - ch_addr(i, 12'h000) < `DEC_CH_STRIDE)
                  hit_map = 1'b1;
            end
         end
      endcase
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         slverr_q <= 1'b0;
      end else if (rd_setup) begin
         prdata_q <= pwrite ? 32'h00000000 : rd_d;
         slverr_q <= !hit_map;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && slverr_q;
endmodule // dec_unit

// >>> dec_map.svh
// Register offsets, field positions and reset values of the debug event unit.
// Assumes a 12-bit APB byte address; every register is one 32-bit word.
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH

// Global register offsets
`define DEC_GCTRL_OFF 12'h000
`define DEC_STAT_OFF  12'h004
`define DEC_MASK_OFF  12'h008
`define DEC_HALT_OFF  12'h00C
// Channel block: channel n sits at base + (n-1) * stride
`define DEC_CH_BASE   12'h100
`define DEC_CH_STRIDE 12'h010
`define DEC_CH_CTRL   12'h000
`define DEC_CH_VAL    12'h004
`define DEC_CH_LIM    12'h008
`define DEC_CH_CNT    12'h00C

// Channel control fields
`define DEC_F_EN      0
`define DEC_F_KIND_LO 1
`define DEC_F_KIND_HI 3
`define DEC_F_USEPC   4
`define DEC_F_SIZE_LO 5
`define DEC_F_SIZE_HI 6
`define DEC_F_RWEN    7
`define DEC_F_RWSEL   8
`define DEC_F_ALT     9
`define DEC_F_BRK     11
`define DEC_F_TRC     12
`define DEC_F_PSTART  13
`define DEC_F_PEND    14
`define DEC_F_CNTEN   15
`define DEC_F_PREV_LO 16
`define DEC_F_PREV_HI 19
`define DEC_F_FLG_LO  20
`define DEC_F_FLG_HI  21

// Global control fields and reset value (branch trace on)
`define DEC_G_SWTR     0
`define DEC_G_BRTR     1
`define DEC_G_BRBRK    2
`define DEC_G_BRTYP_LO 3
`define DEC_G_BRTYP_HI 4
`define DEC_GCTRL_RST  32'h00000002

// Status bits above the per-channel hit bits
`define DEC_S_BRK   12
`define DEC_S_PST   13
`define DEC_S_PEND  14
`define DEC_S_W     15

// Sequencing and trace source codes
`define DEC_PREV_FLAG 4'hD
`define DEC_FLG_SET   2'h1
`define DEC_FLG_CLR   2'h2
`define DEC_SRC_BR    4'hE

`endif

// >>> dec_pkg.sv
// Types shared by the debug event unit modules.
// Assumes nothing of its surroundings.
package dec_pkg;
   // Condition kind held in each channel control word
   typedef enum logic [2:0] {
      DEC_K_ADDR,
      DEC_K_DATA,
      DEC_K_BUS,
      DEC_K_WIN,
      DEC_K_SYS,
      DEC_K_TLB
   } dec_kind_t;
endpackage

// >>> dec_chan_match.sv
// One event channel comparator: raw condition hit, combinational.
// Assumes processor and system bus inputs are synchronous one-cycle strobes.
`timescale 1ns/1ps
`include "dec_map.svh"

module dec_chan_match (
   // Channel configuration
   input  wire logic [31:0] ctrl,
   input  wire logic [31:0] val,
   input  wire logic [31:0] lim,
   // Processor bus
   input  wire logic        cpu_acc_valid,
   input  wire logic        cpu_acc_write,
   input  wire logic [1:0]  cpu_acc_size,
   input  wire logic [31:0] cpu_addr,
   input  wire logic [31:0] cpu_data,
   input  wire logic        cpu_pc_valid,
   input  wire logic [31:0] cpu_pc,
   input  wire logic        xbus_valid,
   input  wire logic [31:0] xbus_addr,
   input  wire logic        ybus_valid,
   input  wire logic [31:0] ybus_addr,
   // System bus and instruction events
   input  wire logic        sbus_valid,
   input  wire logic [31:0] sbus_addr,
   input  wire logic [31:0] sbus_data,
   input  wire logic        tlb_load_instruction,
   // Result
   output logic             hit
);
   import dec_pkg::*;

   logic [1:0]  size;
   logic [31:0] dmask;
   logic        rw_ok;
   dec_kind_t   kind;

   // Field extraction and size mask
   assign kind  = dec_kind_t'(ctrl[`DEC_F_KIND_HI:`DEC_F_KIND_LO]);
   assign size  = ctrl[`DEC_F_SIZE_HI:`DEC_F_SIZE_LO];
   assign dmask = (size == 2'h0) ? 32'h000000FF :
                  (size == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
   assign rw_ok = !ctrl[`DEC_F_RWEN] ||
                  (ctrl[`DEC_F_RWSEL] == !cpu_acc_write);

   // Condition evaluation per kind
   always_comb begin
      hit = 1'b0;
      unique case (kind)
         DEC_K_ADDR: hit = ctrl[`DEC_F_USEPC] ?
                     (cpu_pc_valid && cpu_pc == val) :
                     (cpu_acc_valid && cpu_addr == val);
         DEC_K_DATA: hit = cpu_acc_valid && cpu_acc_size == size &&
                     (cpu_data & dmask) == (val & dmask);
         DEC_K_BUS: begin
            if (ctrl[`DEC_F_USEPC])
               hit = cpu_acc_valid && (cpu_data & dmask) == (val & dmask);
            else if (ctrl[`DEC_F_ALT])
               hit = ybus_valid && ybus_addr == val;
            else
               hit = xbus_valid && xbus_addr == val;
            hit = hit && rw_ok;
         end
         DEC_K_WIN: hit = cpu_acc_valid && cpu_addr >= val &&
                    cpu_addr <= lim;
         DEC_K_SYS: hit = sbus_valid && (ctrl[`DEC_F_ALT] ?
                    sbus_data == val : sbus_addr == val);
         DEC_K_TLB: hit = tlb_load_instruction;
         default:   hit = 1'b0;
      endcase
      hit = hit && ctrl[`DEC_F_EN];
   end
endmodule // dec_chan_match

// >>> dec_seq.sv
// Channel chaining: prerequisite channels and the sequence match flag.
// Assumes raw hits are one-cycle strobes from the channel comparators.
`timescale 1ns/1ps
`include "dec_map.svh"

module dec_seq #(
   parameter int NCH = 12
) (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Configuration and hits
   input  wire logic [NCH-1:0]      raw,
   input  wire logic [NCH-1:0][3:0] prev,
   input  wire logic [NCH-1:0][1:0] flg_act,
   input  wire logic                brk,
   // Results
   output logic      [NCH-1:0]      eff,
   output logic      [NCH-1:0]      prereq,
   output logic                     flag
);
   logic [NCH-1:0] armed_q;
   logic           flag_q;

   // Qualify each hit by its prerequisite
   always_comb begin
      prereq = '0;
      for (int i = 0; i < NCH; i++) begin
         if (prev[i] == `DEC_PREV_FLAG)
            eff[i] = raw[i] && flag_q;
         else if (prev[i] != 4'h0 && int'(prev[i]) <= NCH)
            eff[i] = raw[i] && armed_q[int'(prev[i]) - 1];
         else
            eff[i] = raw[i];
         for (int j = 0; j < NCH; j++)
            if (int'(prev[j]) == i + 1)
               prereq[i] = 1'b1;
      end
   end

   // Remember satisfied channels until the next break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         armed_q <= '0;
      else if (brk)
         armed_q <= '0;
      else
         armed_q <= armed_q | eff;
   end

   // Sequence match flag, initialised by every break
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         flag_q <= 1'b0;
      else if (brk)
         flag_q <= 1'b0;
      else
         for (int i = 0; i < NCH; i++)
            if (eff[i] && flg_act[i] == `DEC_FLG_SET)
               flag_q <= 1'b1;
            else if (eff[i] && flg_act[i] == `DEC_FLG_CLR)
               flag_q <= 1'b0;
   end

   assign flag = flag_q;
endmodule // dec_seq

// >>> dec_unit_properties.sv
// Port checker for dec_unit: APB answer, break, trace and perf pulses.
// Assumes it is bound to dec_unit and sees only that module's ports.
`timescale 1ns/1ps
`include "dec_map.svh"
module dec_unit_properties (
   // Clock, reset and APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Events
   input wire logic        cpu_acc_valid,
   input wire logic        cpu_pc_valid,
   input wire logic        xbus_valid,
   input wire logic        ybus_valid,
   input wire logic        sbus_valid,
   input wire logic        tlb_load_instruction,
   input wire logic        branch_valid,
   input wire logic        sw_trace_valid,
   // Actions
   input wire logic        cpu_halt,
   input wire logic        host_break,
   input wire logic        trace_capture,
   input wire logic [3:0]  trace_src,
   input wire logic        sw_trace_capture,
   input wire logic        perf_start,
   input wire logic        perf_end
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Any core or bus event except a software trace offer, and a resume write
   wire ev = cpu_acc_valid | cpu_pc_valid | xbus_valid | ybus_valid |
             sbus_valid | tlb_load_instruction | branch_valid;
   wire resume = psel & penable & pwrite & pwdata[0] &
                 (paddr == `DEC_HALT_OFF);
   ////////////////////////////////////////////////////////////////////
   sequence s_brk_pulse; host_break ##1 !host_break; endsequence
   sequence s_stopped; cpu_halt && !resume; endsequence
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("pslverr out of access");
   property p_notify; $rose(cpu_halt) |-> host_break; endproperty
   a_notify: assert property (p_notify) else $error("silent halt");
   property p_pulse; host_break |-> s_brk_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("break too long");
   property p_quiet; host_break |-> !$past(cpu_halt); endproperty
   a_quiet: assert property (p_quiet) else $error("break when halted");
   property p_hold; s_stopped |=> cpu_halt; endproperty
   a_hold: assert property (p_hold) else $error("halt dropped");
   property p_resume; cpu_halt && resume && !ev |=> !cpu_halt; endproperty
   a_resume: assert property (p_resume) else $error("no resume");
   property p_src; trace_capture |-> trace_src inside {[1:12], 14};
   endproperty
   a_src: assert property (p_src) else $error("bad trace source");
   property p_cause;
      trace_capture || perf_start || perf_end || host_break |-> $past(ev);
   endproperty
   a_cause: assert property (p_cause) else $error("action no event");
   property p_sw; sw_trace_capture |-> $past(sw_trace_valid); endproperty
   a_sw: assert property (p_sw) else $error("sw trace no offer");
endmodule // dec_unit_properties
bind dec_unit dec_unit_properties dec_unit_properties_inst (.*);

// >>> dec_cpu_model.sv
// Processor and system bus model: issues one-cycle event strobes.
// Assumes the caller starts each event anywhere; it aligns to pclk.
`timescale 1ns/1ps
module dec_cpu_model (
   // Clock
   input  wire logic  pclk,
   // Strobes and buses
   output logic        cpu_acc_valid,
   output logic        cpu_acc_write,
   output logic [1:0]  cpu_acc_size,
   output logic [31:0] cpu_addr,
   output logic [31:0] cpu_data,
   output logic        cpu_pc_valid,
   output logic [31:0] cpu_pc,
   output logic        xbus_valid,
   output logic [31:0] xbus_addr,
   output logic        ybus_valid,
   output logic [31:0] ybus_addr,
   output logic        sbus_valid,
   output logic [31:0] sbus_addr,
   output logic [31:0] sbus_data,
   output logic        tlb_load_instruction,
   output logic        branch_valid,
   output logic [1:0]  branch_type,
   output logic        sw_trace_valid
);
   logic [7:0] stb;
   // Strobe k: acc, pc, x, y, sys, tlb, branch, sw trace
   assign {sw_trace_valid, branch_valid, tlb_load_instruction, sbus_valid,
           ybus_valid, xbus_valid, cpu_pc_valid, cpu_acc_valid} = stb;
   initial begin
      stb = 8'h00;
      {cpu_acc_write, cpu_acc_size, branch_type} = 5'h00;
      {cpu_addr, cpu_pc, xbus_addr, ybus_addr, sbus_addr} = '0;
      {cpu_data, sbus_data} = '0;
   end
   // One event; idle buses show the inverse so stale values never match
   task automatic fire(input int k, input logic [31:0] a, d,
                       input logic [2:0] m);
      @(posedge pclk);
      {cpu_acc_write, cpu_acc_size} <= m;
      branch_type <= m[1:0];
      {cpu_addr, cpu_pc, xbus_addr, ybus_addr, sbus_addr} <= {5{a}};
      {cpu_data, sbus_data} <= {2{d}};
      stb <= 8'h01 << k;
      @(posedge pclk);
      stb <= 8'h00;
      {cpu_addr, cpu_pc, xbus_addr, ybus_addr, sbus_addr} <= {5{~a}};
      {cpu_data, sbus_data} <= {2{~d}};
   endtask
endmodule // dec_cpu_model

// >>> dec_unit_test.sv
// Testbench of dec_unit: APB register tasks and event scenarios.
// Assumes dec_cpu_model drives the core side and the checker is bound.
`timescale 1ns/1ps
`include "dec_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module dec_unit_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cpu_addr, cpu_data, cpu_pc, xbus_addr;
   logic [31:0] ybus_addr, sbus_addr, sbus_data, r;
   logic        cpu_acc_valid, cpu_acc_write, cpu_pc_valid, xbus_valid;
   logic        ybus_valid, sbus_valid, tlb_load_instruction, branch_valid;
   logic        sw_trace_valid, cpu_halt, host_break, trace_capture;
   logic        sw_trace_capture, perf_start, perf_end;
   logic [1:0]  cpu_acc_size, branch_type;
   logic [3:0]  trace_src;
   int          num_errors = 0;
   int          num_checks = 0;
   wire  [5:0]  acts = {cpu_halt, host_break, trace_capture,
                        sw_trace_capture, perf_start, perf_end};
   dec_unit dec_unit_inst (.*);
   dec_cpu_model dec_cpu_model_inst (.*);
   // Clock
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // APB transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, r, e);
      `CHK("prdata", x, r);
   endtask
   function automatic logic [11:0] ch(input int n, input logic [11:0] o);
      return `DEC_CH_BASE + `DEC_CH_STRIDE * 12'(n - 1) + o;
   endfunction
   task automatic cfg(input int n, input logic [31:0] c, v);
      wr(ch(n, `DEC_CH_VAL), v);
      wr(ch(n, `DEC_CH_CTRL), c);
   endtask
   // One event, then the action pulses one cycle later
   task automatic act(input int k, input logic [31:0] a, d,
                      input logic [2:0] m, input logic [5:0] x);
      dec_cpu_model_inst.fire(k, a, d, m);
      #1;
      `CHK("actions", x, acts);
   endtask
   task automatic go();
      wr(`DEC_HALT_OFF, 32'h1);
      `CHK("cpu_halt", 1'b0, cpu_halt);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and the end of the channel map
      rd(`DEC_GCTRL_OFF, 32'h00000002);
      rd(`DEC_HALT_OFF, 32'h00000000);
      rd(ch(12, `DEC_CH_CTRL), 32'h0);
      wr(ch(12, `DEC_CH_VAL), 32'h0000A5C3);
      rd(ch(12, `DEC_CH_VAL), 32'h0000A5C3);
      apb(1'b0, ch(13, `DEC_CH_CTRL), 32'h0, r, e);
      `CHK("pslverr", 1'b1, e);
      `CHK("prdata", 32'h0, r);
      // Branch trace on by default, software trace selector
      act(6, 32'h0, 32'h0, 3'h0, 6'b001000);
      `CHK("trace_src", 4'hE, trace_src);
      act(7, 32'h0, 32'h0, 3'h0, 6'b000000);
      wr(`DEC_GCTRL_OFF, 32'h3);
      act(7, 32'h0, 32'h0, 3'h0, 6'b000100);
      // Address break, status, interrupt and resume
      cfg(1, 32'h801, 32'h1000);
      act(0, 32'h1004, 32'h0, 3'h2, 6'b000000);
      act(0, 32'h1000, 32'h0, 3'h2, 6'b110000);
      rd(`DEC_STAT_OFF, 32'h00001001);
      wr(`DEC_MASK_OFF, 32'h1000);
      `CHK("irq", 1'b1, irq);
      wr(`DEC_STAT_OFF, 32'h1001);
      `CHK("irq", 1'b0, irq);
      go();
      cfg(1, 32'h811, 32'h1100);
      act(1, 32'h1100, 32'h0, 3'h0, 6'b110000);
      go();
      // Data size, direction and X/Y bus channels
      cfg(2, 32'h1023, 32'h55AA);
      act(0, 32'h0, 32'h55AA, 3'h0, 6'b000000);
      act(0, 32'h0, 32'h55AA, 3'h1, 6'b001000);
      `CHK("trace_src", 4'h2, trace_src);
      cfg(3, 32'h1195, 32'h6666);
      act(0, 32'h0, 32'h6666, 3'h6, 6'b000000);
      act(0, 32'h0, 32'h6666, 3'h2, 6'b001000);
      for (int i = 0; i < 2; i++) begin
         cfg(4, 32'h1005 | (i << 9), 32'h7000);
         act(2 + i, 32'h7000, 32'h0, 3'h0, 6'b001000);
      end
      // Window upper bound, system bus data, TLB load
      cfg(5, 32'h1007, 32'h2000);
      wr(ch(5, `DEC_CH_LIM), 32'h20FF);
      act(0, 32'h20FF, 32'h0, 3'h2, 6'b001000);
      act(0, 32'h2100, 32'h0, 3'h2, 6'b000000);
      cfg(8, 32'h1209, 32'h77);
      act(4, 32'h1, 32'h77, 3'h0, 6'b001000);
      `CHK("trace_src", 4'h8, trace_src);
      cfg(7, 32'hB, 32'h0);
      act(5, 32'h0, 32'h0, 3'h0, 6'b110000);
      go();
      // Performance start and end, then count of three
      for (int j = 0; j < 2; j++) begin
         cfg(6, j ? 32'h4011 : 32'h2011, 32'h4000);
         act(1, 32'h4000, 32'h0, 3'h0, j ? 6'b000001 : 6'b000010);
      end
      cfg(2, 32'h8811, 32'h3000);
      wr(ch(2, `DEC_CH_CNT), 32'h3);
      for (int i = 1; i <= 3; i++) begin
         act(1, 32'h3000, 32'h0, 3'h0, (i == 3) ? 6'b110000 : 6'b0);
      end
      go();
      // Channel 2 then 1; order reversed first, memory cleared by break
      cfg(2, 32'h11, 32'h5100);
      cfg(1, 32'h20811, 32'h5000);
      act(1, 32'h5000, 32'h0, 3'h0, 6'b000000);
      act(1, 32'h5100, 32'h0, 3'h0, 6'b000000);
      act(1, 32'h5000, 32'h0, 3'h0, 6'b110000);
      go();
      act(1, 32'h5000, 32'h0, 3'h0, 6'b000000);
      print_verdict();
   end
endmodule // dec_unit_test
